// ===== hw/sahi_params.svh
// constants of the sar adc parallel host interface
`ifndef SAHI_PARAMS_SVH
`define SAHI_PARAMS_SVH

`define SAHI_RES_W          12
`define SAHI_MSB_IDX        4'hb
`define SAHI_CLK_MHZ        50
// one bit decision step, and the sample hand-over step
`define SAHI_BIT_STEP_NS    500
`define SAHI_BIT_STEP_CYC   ((`SAHI_BIT_STEP_NS * `SAHI_CLK_MHZ) / 1000)
`define SAHI_CNT_W          5
// reference settling after sleep release, in microseconds
`define SAHI_REF_SETTLE_US  4200
`define SAHI_REF_SETTLE_CYC (`SAHI_REF_SETTLE_US * `SAHI_CLK_MHZ)
`define SAHI_REF_CNT_W      18
`define SAHI_FIFO_DEPTH     8

`endif

// ===== hw/sahi_pkg.sv
// types of the sar adc parallel host interface
`include "sahi_params.svh"
`default_nettype none
package sahi_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_DECIDE = 2'b10,
        ST_STORE  = 2'b11
    } sahi_state_t;

    // host strobes, all active low except the byte select
    typedef struct packed {
        logic cs_n;
        logic conv_start_n;
        logic rd_n;
        logic upper_byte_select;
    } sahi_host_t;

    // static mode and power pins
    typedef struct packed {
        logic sleep_n;
        logic nap_n;
        logic byte_mode;
        logic bipolar;
    } sahi_mode_t;

    typedef logic [`SAHI_RES_W-1:0] sahi_word_t;
endpackage : sahi_pkg
`default_nettype wire

// ===== hw/sahi_fifo.sv
// result queue between the converter and the output latches
`default_nettype none
module sahi_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_word,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    wire do_push = in_valid & in_ready;
    wire do_pop  = out_valid & out_ready;

    assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) | (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign out_word  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (clk_en) begin
            if (do_push) wr_q <= wr_q + 1'b1;
            if (do_pop)  rd_q <= rd_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clk_en && do_push) mem_q[wr_q[AW-1:0]] <= in_word;
    end
endmodule : sahi_fifo
`default_nettype wire

// ===== hw/sahi_core.sv
// control, successive approximation sequencer and parallel read port
`include "sahi_params.svh"
`default_nettype none
module sahi_core
    import sahi_pkg::*;
#(
    parameter int REF_SETTLE_CYCLES = `SAHI_REF_SETTLE_CYC
) (
    // clock, reset, freeze
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // host strobes and mode pins
    input  wire sahi_host_t  host,
    input  wire sahi_mode_t  mode,
    // comparator: dac trial level above the held input
    input  wire logic        dac_above,
    // analog side controls
    output logic             sample_hold,
    output sahi_word_t       dac_code,
    output logic             conv_power_on,
    output logic             ref_power_on,
    // status pins
    output logic             busy_n,
    output logic             reference_ready,
    // three-state data bus, enable low while driving
    output sahi_word_t       data_out,
    output sahi_word_t       data_oe_n
);
    localparam int STEP_LAST = `SAHI_BIT_STEP_CYC - 1;

    // =========================================================
    // output coding
    // =========================================================
    // the sar yields offset binary in bipolar operation
    function automatic sahi_word_t code_result(input sahi_word_t sar,
                                               input logic byte_mode,
                                               input logic bipolar);
        sahi_word_t w;
        w = sar;
        if (bipolar && !byte_mode) w[`SAHI_RES_W-1] = ~sar[`SAHI_RES_W-1];
        return w;
    endfunction : code_result

    function automatic sahi_word_t bit_mask(input logic [3:0] idx);
        return sahi_word_t'(1) << idx;
    endfunction : bit_mask

    // =========================================================
    // state
    // =========================================================
    sahi_state_t                 state_q;
    logic [`SAHI_CNT_W-1:0]      cnt_q;
    logic [3:0]                  bit_idx_q;
    sahi_word_t                  sar_q;
    logic                        start_prev_q;
    logic                        rd_prev_q;
    logic                        busy_n_q;
    logic                        hold_q;
    logic [`SAHI_REF_CNT_W-1:0]  ref_cnt_q;
    logic                        ref_ready_q;
    logic                        conv_pwr_q;
    logic                        ref_pwr_q;
    sahi_word_t                  latch_q;
    logic                        latch_full_q;
    sahi_word_t                  data_q;
    sahi_word_t                  oe_n_q;

    logic                        fifo_in_ready;
    logic                        fifo_out_valid;
    sahi_word_t                  fifo_out_word;

    // =========================================================
    // decode
    // =========================================================
    wire selected    = ~host.cs_n;
    wire start_fall  = start_prev_q & ~host.conv_start_n & selected;
    wire napping     = mode.byte_mode & ~mode.nap_n;
    wire can_start   = ref_ready_q & mode.sleep_n & ~napping & fifo_in_ready;
    wire start_take  = start_fall & can_start & (state_q == ST_IDLE);
    wire step_end    = (cnt_q == `SAHI_CNT_W'(STEP_LAST));
    wire last_bit    = (bit_idx_q == 4'h0);
    wire [3:0] next_idx = bit_idx_q - 4'h1;
    wire read_active = ~host.rd_n & selected;
    wire read_end    = ~rd_prev_q & host.rd_n & selected;
    wire consume     = read_end & (~mode.byte_mode | host.upper_byte_select);
    wire fifo_pop    = fifo_out_valid & (~latch_full_q | consume);
    wire store_push  = (state_q == ST_STORE);
    wire sahi_word_t store_word = code_result(sar_q, mode.byte_mode, mode.bipolar);

    // keep or drop the bit under test, then raise the next trial bit
    wire sahi_word_t sar_kept = dac_above ? (sar_q & ~bit_mask(bit_idx_q)) : sar_q;
    wire sahi_word_t sar_next = last_bit ? sar_kept : (sar_kept | bit_mask(next_idx));

    // byte lane selection on the read port
    wire sahi_word_t byte_word = host.upper_byte_select
                               ? {8'h00, latch_q[11:8]}
                               : {4'h0, latch_q[7:0]};
    wire sahi_word_t read_word = mode.byte_mode ? byte_word : latch_q;
    wire sahi_word_t oe_n_next = {{4{~read_active | mode.byte_mode}},
                                  {8{~read_active}}};

    // =========================================================
    // conversion sequencer
    // =========================================================
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q   <= ST_IDLE;
            cnt_q     <= '0;
            bit_idx_q <= 4'h0;
            sar_q     <= '0;
            busy_n_q  <= 1'b1;
            hold_q    <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= step_end ? '0 : cnt_q + 1'b1;
            if (!mode.sleep_n) begin
                state_q  <= ST_IDLE;
                busy_n_q <= 1'b1;
                hold_q   <= 1'b0;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (start_take) begin
                            state_q  <= ST_SAMPLE;
                            sar_q    <= '0;
                            cnt_q    <= '0;
                            busy_n_q <= 1'b0;
                            hold_q   <= 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        if (step_end) begin
                            state_q   <= ST_DECIDE;
                            bit_idx_q <= `SAHI_MSB_IDX;
                            sar_q     <= bit_mask(`SAHI_MSB_IDX);
                        end
                    end
                    ST_DECIDE: begin
                        if (step_end) begin
                            sar_q     <= sar_next;
                            bit_idx_q <= next_idx;
                            if (last_bit) state_q <= ST_STORE;
                        end
                    end
                    ST_STORE: begin
                        // queue space was checked when the start was taken
                        state_q  <= ST_IDLE;
                        busy_n_q <= 1'b1;
                        hold_q   <= 1'b0;
                    end
                endcase
            end
        end
    end

    // =========================================================
    // strobe history
    // =========================================================
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            start_prev_q <= 1'b1;
            rd_prev_q    <= 1'b1;
        end else if (clk_en) begin
            start_prev_q <= host.conv_start_n;
            rd_prev_q    <= host.rd_n | host.cs_n;
        end
    end

    // =========================================================
    // power and reference settling
    // =========================================================
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ref_cnt_q   <= '0;
            ref_ready_q <= 1'b0;
            conv_pwr_q  <= 1'b0;
            ref_pwr_q   <= 1'b0;
        end else if (clk_en) begin
            ref_pwr_q  <= mode.sleep_n;
            conv_pwr_q <= mode.sleep_n & ~napping;
            if (!mode.sleep_n) begin
                ref_cnt_q   <= '0;
                ref_ready_q <= 1'b0;
            end else if (!ref_ready_q) begin
                if (ref_cnt_q == `SAHI_REF_CNT_W'(REF_SETTLE_CYCLES - 1))
                    ref_ready_q <= 1'b1;
                else
                    ref_cnt_q <= ref_cnt_q + 1'b1;
            end
        end
    end

    // =========================================================
    // result queue and output latches
    // =========================================================
    sahi_fifo #(
        .WIDTH (`SAHI_RES_W),
        .DEPTH (`SAHI_FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (store_push),
        .in_ready  (fifo_in_ready),
        .in_word   (store_word),
        .out_valid (fifo_out_valid),
        .out_ready (~latch_full_q | consume),
        .out_word  (fifo_out_word)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            latch_q      <= '0;
            latch_full_q <= 1'b0;
        end else if (clk_en) begin
            if (fifo_pop) begin
                latch_q      <= fifo_out_word;
                latch_full_q <= 1'b1;
            end else if (consume) begin
                latch_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            data_q <= '0;
            oe_n_q <= '1;
        end else if (clk_en) begin
            data_q <= read_word;
            oe_n_q <= oe_n_next;
        end
    end

    assign busy_n          = busy_n_q;
    assign reference_ready = ref_ready_q;
    assign sample_hold     = hold_q;
    assign dac_code        = sar_q;
    assign conv_power_on   = conv_pwr_q;
    assign ref_power_on    = ref_pwr_q;
    assign data_out        = data_q;
    assign data_oe_n       = oe_n_q;

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b || !clk_en);

    sequence conv_begin;
        start_take ##1 (state_q == ST_SAMPLE && !busy_n_q);
    endsequence

    sequence conv_finish;
        (state_q == ST_STORE) ##1 (busy_n_q && state_q == ST_IDLE);
    endsequence

    start_begins_a: assert property (start_take |-> conv_begin)
        else $error("accepted start did not begin a conversion");
    unselected_ignore_a: assert property ((state_q == ST_IDLE && host.cs_n)
        |=> state_q == ST_IDLE)
        else $error("conversion began without chip select");
    drive_gate_a: assert property (!data_oe_n[0]
        |-> $past(!host.rd_n && !host.cs_n))
        else $error("data driven outside a selected read");
    busy_span_a: assert property ((state_q != ST_IDLE) |-> !busy_n_q)
        else $error("busy released during conversion");
    busy_end_a: assert property ($rose(busy_n_q) && $past(mode.sleep_n) && $past(rst_b)
        |-> $past(state_q) == ST_STORE)
        else $error("busy rose without a finished conversion");
    sar_clear_a: assert property ($rose(state_q == ST_SAMPLE) |-> sar_q == '0)
        else $error("approximation register not cleared at start");
    no_restart_a: assert property ((state_q != ST_IDLE && start_fall)
        |=> !$rose(state_q == ST_SAMPLE))
        else $error("conversion restarted by a second start edge");
    msb_order_a: assert property ((state_q == ST_DECIDE && step_end && !last_bit
        && mode.sleep_n) |=> bit_idx_q == $past(bit_idx_q) - 4'h1)
        else $error("bit decisions out of order");
    store_word_a: assert property (store_push |-> conv_finish)
        else $error("finished word not handed on");
    sleep_ref_a: assert property (!mode.sleep_n |=> !ref_ready_q)
        else $error("reference ready high in sleep");
    ref_settle_a: assert property ($rose(ref_ready_q)
        |-> $past(ref_cnt_q) == `SAHI_REF_CNT_W'(REF_SETTLE_CYCLES - 1))
        else $error("reference ready before settling count");
    nap_off_a: assert property ((mode.byte_mode && !mode.nap_n)
        |=> !conv_power_on && (ref_power_on == $past(mode.sleep_n)))
        else $error("nap did not power down the converter only");
    high_byte_a: assert property ((mode.byte_mode && host.upper_byte_select)
        |=> data_out[7:4] == 4'h0 && data_out[3:0] == $past(latch_q[11:8]))
        else $error("high byte lanes wrong");

    sequence sample_open;
        state_q == ST_SAMPLE && hold_q && sar_q == '0;
    endsequence

    sequence first_trial;
        state_q == ST_DECIDE && bit_idx_q == `SAHI_MSB_IDX && sar_q == bit_mask(`SAHI_MSB_IDX);
    endsequence

    sequence bus_released;
        data_oe_n == '1;
    endsequence

    start_gate_a: assert property
        ((state_q == ST_IDLE && !start_fall) |=> state_q == ST_IDLE)
        else $error("conversion began without a selected falling start");
    sample_enter_a: assert property
        (start_take |=> sample_open)
        else $error("conversion did not open with a cleared register");
    msb_first_a: assert property
        ((state_q == ST_SAMPLE && step_end && mode.sleep_n) |=> first_trial)
        else $error("first trial was not the most significant bit");
    sleep_abort_a: assert property
        (!mode.sleep_n |=> (state_q == ST_IDLE && busy_n_q))
        else $error("sleep did not stop the converter");
    ref_refuse_a: assert property
        ((state_q == ST_IDLE && !ref_ready_q) |=> state_q == ST_IDLE)
        else $error("conversion began before the reference settled");
    nap_refuse_a: assert property
        ((state_q == ST_IDLE && napping) |=> state_q == ST_IDLE)
        else $error("conversion began during nap");

    bus_release_a: assert property
        (!read_active |=> bus_released)
        else $error("data lines driven outside a selected read");
    upper_lanes_a: assert property
        (mode.byte_mode |=> data_oe_n[11:8] == 4'hf)
        else $error("upper lines driven in byte mode");
    low_byte_a: assert property
        ((mode.byte_mode && !host.upper_byte_select) |=> data_out == {4'h0, $past(latch_q[7:0])})
        else $error("low byte lanes wrong");
    word_lanes_a: assert property
        (!mode.byte_mode |=> data_out == $past(latch_q))
        else $error("word lanes wrong");
    latch_load_a: assert property
        (fifo_pop |=> (latch_full_q && latch_q == $past(fifo_out_word)))
        else $error("queued word not moved into the output latch");

    byte_code_a: assert property
        ((store_push && mode.byte_mode) |-> store_word == sar_q)
        else $error("byte variant coding wrong");
    word_code_a: assert property
        ((store_push && !mode.byte_mode) |-> store_word == (mode.bipolar ? (sar_q ^ 12'h800) : sar_q))
        else $error("word variant coding wrong");
endmodule : sahi_core
`default_nettype wire

// ===== test/sahi_host_model.sv
// host side model: strobes conversions and reads the parallel bus
`default_nettype none
module sahi_host_model
    import sahi_pkg::*;
(
    // clock
    input  wire logic       core_clk,
    // device pins
    output var sahi_host_t  host,
    input  wire logic       busy_n,
    input  wire logic       reference_ready,
    input  wire sahi_word_t data_out,
    input  wire sahi_word_t data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    int idle_cyc = 0;

    initial host = '{cs_n: 1'b1, conv_start_n: 1'b1, rd_n: 1'b1, upper_byte_select: 1'b0};

    // idle time since the result was taken at the busy rise
    always @(posedge core_clk) idle_cyc <= (busy_n === 1'b0) ? 0 : idle_cyc + 1;

    // honoured starts wait for the reference and the acquisition time, then
    // give a second fall while busy that must be ignored
    task automatic start(input logic sel, input logic honor);
        if (honor) begin
            while (!reference_ready || idle_cyc < 100) @(negedge core_clk);
        end
        @(negedge core_clk);
        host.cs_n = !sel;
        @(negedge core_clk);
        repeat (honor ? 2 : 1) begin
            host.conv_start_n = 1'b0;
            repeat (2) @(negedge core_clk);
            host.conv_start_n = 1'b1;
            repeat (2) @(negedge core_clk);
        end
        host.cs_n = 1'b1;
    endtask : start

    // read cycle; rd_n rises while still selected so a word-mode or upper-byte read consumes the word
    task automatic read(input logic sel, input logic ubs, output sahi_word_t d,
                        output sahi_word_t oe);
        @(negedge core_clk);
        host.upper_byte_select = ubs;
        host.cs_n = !sel;
        @(negedge core_clk);
        host.rd_n = 1'b0;
        repeat (2) @(negedge core_clk);
        d = data_out;
        oe = data_oe_n;
        host.rd_n = 1'b1;
        @(negedge core_clk);
        host.cs_n = 1'b1;
    endtask : read
endmodule : sahi_host_model
`default_nettype wire

// ===== test/sahi_core_tb.sv
// self-checking bench of the conversion control and parallel read port
`default_nettype none
module sahi_core_tb
    import sahi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int REF_CYC = 20;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    sahi_host_t host;
    sahi_mode_t mode = '{sleep_n: 1'b1, nap_n: 1'b1, byte_mode: 1'b0, bipolar: 1'b0};
    sahi_word_t level = 12'h000;
    logic       dac_above, sample_hold, conv_power_on, ref_power_on, busy_n, reference_ready;
    sahi_word_t dac_code, data_out, data_oe_n;
    int         bad_count = 0;
    int         checked = 0;
    int         cyc = 0;
    logic [15:0] seed = 16'h0055;

    always #10 core_clk = ~core_clk;
    // comparator: trial level above the held input
    assign dac_above = dac_code > level;

    sahi_core #(.REF_SETTLE_CYCLES(REF_CYC)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .host(host), .mode(mode),
        .dac_above(dac_above), .sample_hold(sample_hold), .dac_code(dac_code),
        .conv_power_on(conv_power_on), .ref_power_on(ref_power_on), .busy_n(busy_n),
        .reference_ready(reference_ready), .data_out(data_out), .data_oe_n(data_oe_n));

    sahi_host_model hm (
        .core_clk(core_clk), .host(host), .busy_n(busy_n), .reference_ready(reference_ready),
        .data_out(data_out), .data_oe_n(data_oe_n));

    // ==================================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic sahi_word_t bus_word(input sahi_word_t lv, input logic ubs);
        sahi_word_t w;
        w = (mode.bipolar && !mode.byte_mode) ? (lv ^ 12'h800) : lv;
        if (!mode.byte_mode) return w;
        return ubs ? {8'h00, w[11:8]} : {4'h0, w[7:0]};
    endfunction : bus_word

    task automatic check(input string what, input sahi_word_t seen, input sahi_word_t exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // follows one conversion: busy span and first trial codes
    task automatic watch(output int len);
        int w;
        w = 0;
        len = 0;
        while (busy_n !== 1'b0 && w < 200) begin
            @(negedge core_clk);
            w++;
        end
        while (busy_n === 1'b0 && len < 400) begin
            if (len == 0) check("dac_clear", dac_code, 12'h000);
            if (len == 0) check("hold_on", 12'(sample_hold), 12'h001);
            if (len == 25) check("dac_msb_trial", dac_code, 12'h800);
            @(negedge core_clk);
            len++;
        end
        check("hold_off", 12'(sample_hold), 12'h000);
    endtask : watch

    task automatic convert(input sahi_word_t lv);
        int len;
        level = lv;
        fork
            hm.start(1'b1, 1'b1);
            watch(len);
        join
        check("busy_span", 12'(len), 12'd326);
    endtask : convert

    task automatic fetch(input sahi_word_t lv);
        sahi_word_t d, oe;
        hm.read(1'b1, 1'b0, d, oe);
        check("low_or_word", d, bus_word(lv, 1'b0));
        check("enables", oe, mode.byte_mode ? 12'hf00 : 12'h000);
        if (mode.byte_mode) begin
            hm.read(1'b1, 1'b1, d, oe);
            check("high_byte", d, bus_word(lv, 1'b1));
        end
    endtask : fetch

    task automatic refused(input logic sel);
        hm.start(sel, 1'b0);
        repeat (3) @(negedge core_clk);
        check("start_ignored", 12'(busy_n), 12'h001);
    endtask : refused

    // whole run is about 8000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            finish_test();
        end
    end

    // ==================================================================
    // scenarios
    initial begin
        sahi_word_t q[$];
        sahi_word_t d, oe;
        sahi_word_t lv;
        sahi_word_t corner[4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
        repeat (16) @(negedge core_clk);
        check("oe_reset", data_oe_n, 12'hfff);
        rst_b = 1'b1;
        refused(1'b1);
        check("ref_settling", 12'(reference_ready), 12'h000);
        repeat (16) @(negedge core_clk);
        check("ref_settled", 12'(reference_ready), 12'h001);
        refused(1'b0);
        hm.read(1'b0, 1'b0, d, oe);
        check("read_unselected", oe, 12'hfff);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            lv = (i < 4) ? corner[i] : seed[11:0];
            mode.byte_mode = i[0];
            mode.bipolar = i[1];
            convert(lv);
            fetch(lv);
        end
        mode.byte_mode = 1'b0;
        mode.nap_n = 1'b0;
        repeat (2) @(negedge core_clk);
        check("word_nap_power", {10'h000, conv_power_on, ref_power_on}, 12'h003);
        mode.byte_mode = 1'b1;
        repeat (2) @(negedge core_clk);
        check("nap_power", {10'h000, conv_power_on, ref_power_on}, 12'h001);
        refused(1'b1);
        mode.nap_n = 1'b1;
        repeat (31) @(negedge core_clk);
        convert(12'h5a3);
        fetch(12'h5a3);
        fork
            hm.start(1'b1, 1'b1);
            wait (busy_n === 1'b0);
        join
        mode.sleep_n = 1'b0;
        repeat (2) @(negedge core_clk);
        check("sleep_abort", 12'(busy_n), 12'h001);
        check("sleep_ref", 12'(reference_ready), 12'h000);
        refused(1'b1);
        mode.sleep_n = 1'b1;
        repeat (25) @(negedge core_clk);
        check("wake_ref", 12'(reference_ready), 12'h001);
        mode.byte_mode = 1'b0;
        mode.bipolar = 1'b0;
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            q.push_back(seed[11:0]);
            convert(seed[11:0]);
        end
        repeat (100) @(negedge core_clk);
        refused(1'b1);
        foreach (q[i]) fetch(q[i]);
        finish_test();
    end
endmodule : sahi_core_tb
`default_nettype wire
